/* File: common/prb_defines.svh */
`ifndef PRB_DEFINES_SVH
`define PRB_DEFINES_SVH

`define PRB_OPC_BEQ     6'h04
`define PRB_OPC_REGIMM  6'h01
`define PRB_OPC_FLOAT_COPROCESSOR_OPCODE    6'h11
`define PRB_RT_BRANCH_NONNEGATIVE_AND_LINK   5'h11
`define PRB_SUB_BC      5'h08
`define PRB_REG_ZERO    5'h00
`define PRB_REG_LINK    5'h1F
`define PRB_LINK_OFS    32'h0000_0008
`define PRB_SLOT_OFS    32'h0000_0004
`define PRB_CC_N        8
`define PRB_CC_W        3
`define PRB_EV_N        5
`define PRB_EV_TAKEN    0
`define PRB_EV_NULL     1
`define PRB_EV_CPU      2
`define PRB_EV_RI       3
`define PRB_EV_LINK     4
`define PRB_CTRL_FPU_OK 0
`define PRB_A_STATUS    8'h00
`define PRB_A_MASK      8'h04
`define PRB_A_CTRL      8'h08
`define PRB_A_CC        8'h0C
`define PRB_A_TARGET    8'h10
`define PRB_A_TAKEN_CNT 8'h14
`define PRB_CTRL_RST    1'h1
`define PRB_F_OPC       31:26
`define PRB_F_RS        25:21
`define PRB_F_RT        20:16
`define PRB_F_CC        20:18
`define PRB_F_ND        17
`define PRB_F_TF        16
`define PRB_F_OFF       15:0
`define PRB_F_SIGN      15
`define PRB_SEXT_W      14
`define PRB_OFS_PAD     2'h0

`endif

/* File: common/prb_pkg.sv */
`include "prb_defines.svh"

package prb_pkg;

    typedef enum logic [1:0] {
        PRB_IDLE = 2'h0,
        PRB_SLOT = 2'h1
    } prb_fsm_t;

    typedef struct packed {
        logic [`PRB_CC_N-1:0] bits;
    } prb_cc_state_t;

    typedef struct packed {
        prb_fsm_t              fsm;
        logic                  pend_taken;
        logic                  pend_null;
        logic [31:0]           pend_target;
        logic                  link_we;
        logic [31:0]           link_data;
        logic                  exc_cpu;
        logic                  exc_ri;
        logic [`PRB_EV_N-1:0]  status;
        logic [`PRB_EV_N-1:0]  mask;
        logic                  fpu_ok;
        logic [31:0]           last_target;
        logic [31:0]           taken_cnt;
        logic [31:0]           rdata;
    } prb_state_t;

endpackage

/* File: common/prb_cc_if.sv */
`timescale 1ns/1ns
`include "prb_defines.svh"

interface prb_cc_if;
    logic                 cmp_we;
    logic [`PRB_CC_W-1:0] cmp_idx;
    logic                 cmp_val;
    logic [`PRB_CC_W-1:0] sel;
    logic                 sel_bit;
    logic [`PRB_CC_N-1:0] bits;

    modport store (
        input  cmp_we,
        input  cmp_idx,
        input  cmp_val,
        input  sel,
        output sel_bit,
        output bits
    );

    modport user (
        output cmp_we,
        output cmp_idx,
        output cmp_val,
        output sel,
        input  sel_bit,
        input  bits
    );
endinterface

/* File: rtl/prb_cc_bits.sv */
`timescale 1ns/1ns
`include "prb_defines.svh"

module prb_cc_bits (
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    prb_cc_if.store   cc
);
    prb_pkg::prb_cc_state_t s_reg;
    prb_pkg::prb_cc_state_t s_next;

    // only the compare write port ever changes a bit
    always_comb begin
        s_next = s_reg;
        for (int i = 0; i < `PRB_CC_N; i++) begin
            if (cc.cmp_we && (cc.cmp_idx == i[`PRB_CC_W-1:0])) begin
                s_next.bits[i] = cc.cmp_val;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cc.bits    = s_reg.bits;
    assign cc.sel_bit = s_reg.bits[cc.sel];

    chk_cc_hold_stable: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !cc.cmp_we |=> $stable(cc.bits))
        else $error("condition bits changed without a compare");
endmodule

/* File: rtl/prb_branch_unit.sv */
// Functional notes
// - the always-branch idiom is a branch-if-equal on two zero registers.
// - target is delay-slot address plus the offset shifted two, extended.
// - the always-call idiom is a nonnegative-and-link test of zero.
// - the call writes register 31 with the branch address plus 8.
// - the fp false branch is taken on a 0 bit, after the delay slot.
// - a likely branch not taken kills its delay slot, else slot runs.
// - all four fp branches share one decode, split by polarity and null.
// - the three-bit select field at 20..18 picks the tested bit.
// - eight condition bits exist, each set by compare, read by branch.
// - the tested bits change only through the fp compare.
// - fp branches raise coprocessor-unusable with fpu_ok clear, reserved-instruction without FPU_IMPL.
// - the fp true branch is taken on a 1 bit, after the delay slot.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "prb_defines.svh"

module prb_branch_unit #(
    parameter bit FPU_IMPL = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        in_valid,
    input  wire logic [31:0] in_instr,
    input  wire logic [31:0] in_pc,
    input  wire logic [31:0] rs_val,
    input  wire logic [31:0] rt_val,
    input  wire logic        cmp_we,
    input  wire logic [2:0]  cmp_idx,
    input  wire logic        cmp_val,
    output logic             redirect_valid,
    output logic      [31:0] redirect_pc,
    output logic             slot_kill,
    output logic             link_we,
    output logic      [4:0]  link_addr,
    output logic      [31:0] link_data,
    output logic             exc_cop_unusable,
    output logic             exc_reserved
);
    logic                 rst_meta;
    logic                 rst_sync_n;
    prb_pkg::prb_state_t  s_reg;
    prb_pkg::prb_state_t  s_next;
    prb_cc_if             cc ();

    logic [5:0]           f_opc;
    logic [4:0]           f_rs;
    logic [4:0]           f_rt;
    logic [15:0]          f_off;
    logic                 f_nd;
    logic                 f_tf;
    logic                 is_beq;
    logic                 is_bal;
    logic                 is_fpb;
    logic                 is_br;
    logic                 cond;
    logic                 fp_ri;
    logic                 fp_cpu;
    logic                 accept;
    logic                 in_slot;
    logic                 slot_go;
    logic [31:0]          slot_addr;
    logic [31:0]          disp;
    logic [`PRB_EV_N-1:0] ev;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    prb_cc_bits u_cc (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .cc         (cc.store)
    );

    assign cc.cmp_we  = cmp_we;
    assign cc.cmp_idx = cmp_idx;
    assign cc.cmp_val = cmp_val;
    assign cc.sel     = in_instr[`PRB_F_CC];

    // instruction field split
    assign f_opc = in_instr[`PRB_F_OPC];
    assign f_rs  = in_instr[`PRB_F_RS];
    assign f_rt  = in_instr[`PRB_F_RT];
    assign f_off = in_instr[`PRB_F_OFF];
    assign f_nd  = in_instr[`PRB_F_ND];
    assign f_tf  = in_instr[`PRB_F_TF];

    assign in_slot   = (s_reg.fsm == prb_pkg::PRB_SLOT);
    assign slot_go   = in_valid && in_slot;
    assign slot_addr = in_pc + `PRB_SLOT_OFS;
    assign disp      = {{`PRB_SEXT_W{f_off[`PRB_F_SIGN]}}, f_off,
                        `PRB_OFS_PAD};

    always_comb begin
        is_beq = (f_opc == `PRB_OPC_BEQ);
        is_bal = (f_opc == `PRB_OPC_REGIMM) && (f_rt == `PRB_RT_BRANCH_NONNEGATIVE_AND_LINK);
        // one decode for all four fp forms
        is_fpb = (f_opc == `PRB_OPC_FLOAT_COPROCESSOR_OPCODE) && (f_rs == `PRB_SUB_BC);
        is_br  = is_beq || is_bal || is_fpb;
        fp_ri  = is_fpb && !FPU_IMPL;
        fp_cpu = is_fpb && FPU_IMPL && !s_reg.fpu_ok;
        // a branch seen in a delay slot is only the slot's work
        accept = in_valid && !in_slot && is_br && !fp_ri && !fp_cpu;
        cond   = 1'b0;
        if (is_beq) begin
            // zero against zero always compares equal
            cond = ((f_rs == `PRB_REG_ZERO) && (f_rt == `PRB_REG_ZERO))
                || (rs_val == rt_val);
        end else if (is_bal) begin
            // zero register is never negative
            cond = (f_rs == `PRB_REG_ZERO) || !rs_val[31];
        end else if (is_fpb) begin
            // polarity bit low tests for 0, high for 1
            cond = (cc.sel_bit == f_tf);
        end
    end

    always_comb begin
        ev = '0;
        ev[`PRB_EV_TAKEN] = in_valid && in_slot && s_reg.pend_taken;
        ev[`PRB_EV_NULL]  = in_valid && in_slot && s_reg.pend_null;
        ev[`PRB_EV_CPU]   = in_valid && !in_slot && fp_cpu;
        ev[`PRB_EV_RI]    = in_valid && !in_slot && fp_ri;
        ev[`PRB_EV_LINK]  = accept && is_bal;
    end

    always_comb begin
        s_next         = s_reg;
        s_next.link_we = 1'b0;
        s_next.exc_cpu = ev[`PRB_EV_CPU];
        s_next.exc_ri  = ev[`PRB_EV_RI];
        s_next.rdata   = '0;

        case (s_reg.fsm)
            prb_pkg::PRB_IDLE: begin
                if (accept) begin
                    s_next.fsm         = prb_pkg::PRB_SLOT;
                    s_next.pend_taken  = cond;
                    // likely form, not taken: slot dies
                    s_next.pend_null   = is_fpb && f_nd && !cond;
                    s_next.pend_target = slot_addr + disp;
                end
            end
            prb_pkg::PRB_SLOT: begin
                // the slot instruction runs before any redirect
                if (in_valid) begin
                    s_next.fsm        = prb_pkg::PRB_IDLE;
                    s_next.pend_taken = 1'b0;
                    s_next.pend_null  = 1'b0;
                end
            end
            default: begin
                s_next.fsm        = prb_pkg::PRB_IDLE;
                s_next.pend_taken = 1'b0;
                s_next.pend_null  = 1'b0;
            end
        endcase

        if (ev[`PRB_EV_LINK]) begin
            s_next.link_we   = 1'b1;
            s_next.link_data = in_pc + `PRB_LINK_OFS;
        end

        if (ev[`PRB_EV_TAKEN]) begin
            s_next.last_target = s_reg.pend_target;
            s_next.taken_cnt   = s_reg.taken_cnt + 32'h1;
        end

        // sticky status: hardware set wins over a same-cycle clear
        if (reg_wr && (reg_addr == `PRB_A_STATUS)) begin
            s_next.status = s_reg.status & ~reg_wdata[`PRB_EV_N-1:0];
        end
        s_next.status = s_next.status | ev;

        if (reg_wr) begin
            case (reg_addr)
                `PRB_A_MASK: s_next.mask = reg_wdata[`PRB_EV_N-1:0];
                `PRB_A_CTRL: s_next.fpu_ok = reg_wdata[`PRB_CTRL_FPU_OK];
                `PRB_A_TAKEN_CNT: s_next.taken_cnt = '0;
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                `PRB_A_STATUS: s_next.rdata[`PRB_EV_N-1:0] = s_reg.status;
                `PRB_A_MASK:   s_next.rdata[`PRB_EV_N-1:0] = s_reg.mask;
                `PRB_A_CTRL:   s_next.rdata[`PRB_CTRL_FPU_OK] = s_reg.fpu_ok;
                `PRB_A_CC:     s_next.rdata[`PRB_CC_N-1:0] = cc.bits;
                `PRB_A_TARGET: s_next.rdata = s_reg.last_target;
                `PRB_A_TAKEN_CNT: s_next.rdata = s_reg.taken_cnt;
                default:       s_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_reg        <= '0;
            s_reg.fsm    <= prb_pkg::PRB_IDLE;
            s_reg.fpu_ok <= `PRB_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // redirect only as the slot executes; not taken means no redirect
    assign redirect_valid   = slot_go && s_reg.pend_taken;
    assign redirect_pc      = s_reg.pend_target;
    assign slot_kill        = slot_go && s_reg.pend_null;
    assign link_we          = s_reg.link_we;
    assign link_addr        = `PRB_REG_LINK;
    assign link_data        = s_reg.link_data;
    assign exc_cop_unusable = s_reg.exc_cpu;
    assign exc_reserved     = s_reg.exc_ri;
    assign reg_rdata        = s_reg.rdata;
    assign irq              = |(s_reg.status & s_reg.mask);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n);

    chk_beq_idiom_taken: assert property (
        (accept && is_beq && f_rs == `PRB_REG_ZERO && f_rt == `PRB_REG_ZERO)
        |=> in_slot && s_reg.pend_taken)
        else $error("zero-zero equal branch not taken");

    chk_target_calc: assert property (
        accept |=> s_reg.pend_target ==
            $past(in_pc) + 32'h4 + {{14{$past(f_off[15])}},
            $past(f_off), 2'h0})
        else $error("branch target wrong");

    chk_call_idiom_taken: assert property (
        (accept && is_bal && f_rs == `PRB_REG_ZERO)
        |=> s_reg.pend_taken && link_we)
        else $error("always-call not taken");

    chk_link_value: assert property (
        (accept && is_bal) |=> link_we && link_addr == 5'h1F
            && link_data == $past(in_pc) + 32'h8)
        else $error("link write wrong");

    chk_fp_false_pol: assert property (
        (accept && is_fpb && !f_tf)
        |=> s_reg.pend_taken == !$past(cc.sel_bit))
        else $error("fp false branch polarity wrong");

    chk_fp_true_pol: assert property (
        (accept && is_fpb && f_tf) |=> s_reg.pend_taken == $past(cc.sel_bit))
        else $error("fp true branch polarity wrong");

    chk_likely_kill: assert property (
        (accept && is_fpb && f_nd && !cond) ##1 in_valid
        |-> slot_kill && !redirect_valid)
        else $error("likely slot not killed");

    chk_slot_runs: assert property (
        (accept && !(is_fpb && f_nd)) ##1 in_valid |-> !slot_kill)
        else $error("non-likely slot killed");

    chk_exc_report: assert property (
        (in_valid && !in_slot && is_fpb && !(FPU_IMPL && s_reg.fpu_ok))
        |=> (exc_reserved || exc_cop_unusable) && !in_slot)
        else $error("fp branch exception missing");

    chk_redirect_once: assert property (
        redirect_valid |=> !in_slot && !redirect_valid)
        else $error("redirect repeated");

    chk_cc_write: assert property (
        cmp_we |=> cc.bits[$past(cmp_idx)] == $past(cmp_val))
        else $error("compare did not update its condition bit");

    chk_cc_select: assert property (
        (accept && is_fpb) |=> s_reg.pend_taken ==
            ($past(cc.bits[in_instr[`PRB_F_CC]]) == $past(f_tf)))
        else $error("wrong condition bit tested");

    chk_fp_decode_shared: assert property (
        (in_valid && !in_slot && is_fpb && FPU_IMPL && s_reg.fpu_ok)
        |=> in_slot)
        else $error("fp branch form not accepted");

    chk_link_only_call: assert property (
        (accept && !is_bal) |=> !link_we)
        else $error("link written by a non-call branch");

    chk_likely_taken_runs: assert property (
        (accept && is_fpb && f_nd && cond) ##1 in_valid
        |-> !slot_kill && redirect_valid)
        else $error("taken likely branch lost its slot");

    chk_untaken_no_redirect: assert property (
        (accept && !cond) ##1 in_valid |-> !redirect_valid)
        else $error("untaken branch redirected");

    chk_slot_wait: assert property (
        (in_slot && !in_valid) |=> in_slot)
        else $error("branch left before its slot ran");

    chk_target_hold: assert property (
        (in_slot && !in_valid) |=> $stable(redirect_pc))
        else $error("target moved while waiting for slot");

    chk_accept_no_exc: assert property (
        accept |=> !exc_cop_unusable && !exc_reserved)
        else $error("accepted branch raised an exception");

    chk_cpu_exc_kind: assert property (
        (in_valid && !in_slot && is_fpb && FPU_IMPL && !s_reg.fpu_ok)
        |=> exc_cop_unusable && !exc_reserved)
        else $error("coprocessor-unusable exception wrong");

    chk_ri_exc_kind: assert property (
        (in_valid && !in_slot && is_fpb && !FPU_IMPL)
        |=> exc_reserved && !exc_cop_unusable)
        else $error("reserved-instruction exception wrong");
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ns
`include "prb_defines.svh"

module tb;
    logic        clk_sys;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        in_valid;
    logic [31:0] in_instr;
    logic [31:0] in_pc;
    logic [31:0] rs_val;
    logic [31:0] rt_val;
    logic        cmp_we;
    logic [2:0]  cmp_idx;
    logic        cmp_val;
    logic        redirect_valid;
    logic [31:0] redirect_pc;
    logic        slot_kill;
    logic        link_we;
    logic [4:0]  link_addr;
    logic [31:0] link_data;
    logic        exc_cop_unusable;
    logic        exc_reserved;
    int          n_errors;
    int          checks_done;
    logic        gap;
    logic        nf_exc_reserved;

    prb_branch_unit #(.FPU_IMPL(1'b1)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .in_valid(in_valid),
        .in_instr(in_instr), .in_pc(in_pc), .rs_val(rs_val),
        .rt_val(rt_val), .cmp_we(cmp_we), .cmp_idx(cmp_idx),
        .cmp_val(cmp_val), .redirect_valid(redirect_valid),
        .redirect_pc(redirect_pc), .slot_kill(slot_kill),
        .link_we(link_we), .link_addr(link_addr), .link_data(link_data),
        .exc_cop_unusable(exc_cop_unusable), .exc_reserved(exc_reserved)
    );

    prb_branch_unit #(.FPU_IMPL(1'b0)) dut_nofpu (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .irq(), .in_valid(in_valid),
        .in_instr(in_instr), .in_pc(in_pc), .rs_val(rs_val),
        .rt_val(rt_val), .cmp_we(cmp_we), .cmp_idx(cmp_idx),
        .cmp_val(cmp_val), .redirect_valid(), .redirect_pc(),
        .slot_kill(), .link_we(), .link_addr(), .link_data(),
        .exc_cop_unusable(), .exc_reserved(nf_exc_reserved)
    );

    always #4 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    task automatic fpcmp(input logic [2:0] idx, input logic v);
        @(posedge clk_sys);
        cmp_we  <= 1'b1;
        cmp_idx <= idx;
        cmp_val <= v;
        @(posedge clk_sys);
        cmp_we  <= 1'b0;
    endtask

    // branch, then a plain slot instruction right behind it, or one idle cycle later when gap is set
    task automatic br(input logic [31:0] ins, input logic [31:0] pc,
                      input logic red, input logic kill, input logic lnk,
                      input logic cpu);
        logic [31:0] t;
        t = pc + 32'h0000_0004 + {{14{ins[15]}}, ins[15:0], 2'b00};
        @(posedge clk_sys);
        in_valid <= 1'b1;
        in_instr <= ins;
        in_pc    <= pc;
        @(posedge clk_sys);
        in_valid <= !gap;
        in_instr <= 32'h0000_0000; // plain slot instruction
        in_pc    <= pc + 32'h0000_0004;
        #1;
        chk("link_we", lnk, link_we);
        if (lnk) chk("link_data", pc + 32'h0000_0008, link_data);
        chk("exc_cop_unusable", cpu, exc_cop_unusable);
        chk("exc_reserved", 1'b0, exc_reserved);
        chk("nofpu exc_reserved", ins[31:21] == {6'h11, 5'h08},
            nf_exc_reserved);
        if (gap) begin
            @(posedge clk_sys);
            in_valid <= 1'b1;
            #1;
        end
        chk("redirect_valid", red, redirect_valid);
        if (red) chk("redirect_pc", t, redirect_pc);
        chk("slot_kill", kill, slot_kill);
        @(posedge clk_sys);
        in_valid <= 1'b0;
    endtask

    function automatic logic [31:0] fpbr(input logic [2:0] cc,
                                         input logic nd, input logic tf,
                                         input logic [15:0] off);
        return {6'h11, 5'h08, cc, nd, tf, off};
    endfunction

    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial begin
        clk_sys = 1'b0; rst_n = 1'b0; reg_addr = 8'h00;
        reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
        in_valid = 1'b0; in_instr = 32'h0; in_pc = 32'h0;
        rs_val = 32'h0; rt_val = 32'h0;
        cmp_we = 1'b0; cmp_idx = 3'h0; cmp_val = 1'b0;
        n_errors = 0; checks_done = 0; gap = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd("ctrl", `PRB_A_CTRL, 32'h0000_0001);
        rd("status", `PRB_A_STATUS, 32'h0000_0000);
        rd("cc", `PRB_A_CC, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
        chk("link_addr", 32'h0000_001F, link_addr);
        $display("test reset done");

        wr(`PRB_A_MASK, 32'h0000_0010);
        @(posedge clk_sys); #1;
        chk("irq", 1'b0, irq);
        br({6'h01, 5'h00, 5'h11, 16'h0010}, 32'h0000_1000,
           1'b1, 1'b0, 1'b1, 1'b0);
        @(posedge clk_sys); #1;
        chk("irq", 1'b1, irq);
        rd("status", `PRB_A_STATUS, 32'h0000_0011);
        rd("target", `PRB_A_TARGET, 32'h0000_1044);
        rd("taken", `PRB_A_TAKEN_CNT, 32'h0000_0001);
        wr(`PRB_A_STATUS, 32'h0000_0010);
        @(posedge clk_sys); @(posedge clk_sys); #1;
        chk("irq", 1'b0, irq);
        rd("status", `PRB_A_STATUS, 32'h0000_0001);
        wr(`PRB_A_STATUS, 32'h0000_001F);
        $display("test call done");

        br({6'h04, 5'h00, 5'h00, 16'hFFFF}, 32'h0000_2000,
           1'b1, 1'b0, 1'b0, 1'b0);
        $display("test always branch done");

        fpcmp(3'h5, 1'b1);
        fpcmp(3'h7, 1'b1);
        fpcmp(3'h6, 1'b0);
        rd("cc", `PRB_A_CC, 32'h0000_00A0);
        wr(`PRB_A_CC, 32'h0000_0000);
        rd("cc", `PRB_A_CC, 32'h0000_00A0);
        $display("test compare done");

        for (int k = 0; k < 8; k++) begin
            gap = k[0];
            br(fpbr(k[2] ? 3'h5 : 3'h6, k[1], k[0], 16'h8000),
               32'h0002_0000, k[2] == k[0], k[1] && (k[2] != k[0]), 1'b0,
               1'b0);
        end
        gap = 1'b0;
        br(fpbr(3'h0, 1'b0, 1'b0, 16'h0004), 32'h0000_3000,
           1'b1, 1'b0, 1'b0, 1'b0);
        fpcmp(3'h0, 1'b1);
        br(fpbr(3'h0, 1'b0, 1'b0, 16'h0004), 32'h0000_3000,
           1'b0, 1'b0, 1'b0, 1'b0);
        rd("status", `PRB_A_STATUS, 32'h0000_0003);
        $display("test fp branches done");

        wr(`PRB_A_STATUS, 32'h0000_001F);
        wr(`PRB_A_MASK, 32'h0000_0004);
        wr(`PRB_A_CTRL, 32'h0000_0000);
        br(fpbr(3'h5, 1'b0, 1'b1, 16'h0010), 32'h0000_4000,
           1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge clk_sys); #1;
        chk("irq", 1'b1, irq);
        rd("status", `PRB_A_STATUS, 32'h0000_0004);
        wr(`PRB_A_CTRL, 32'h0000_0001);
        wr(`PRB_A_STATUS, 32'h0000_0004);
        wr(`PRB_A_MASK, 32'h0000_0000);
        br(fpbr(3'h5, 1'b0, 1'b1, 16'h0010), 32'h0000_4000,
           1'b1, 1'b0, 1'b0, 1'b0);
        $display("test exception done");

        wr(`PRB_A_TAKEN_CNT, 32'h0000_0000);
        rd("taken", `PRB_A_TAKEN_CNT, 32'h0000_0000);
        $display("test counter done");
        end_sim();
    end
endmodule
